// [logic/afe_monitor_control_logic.sv]
// Control logic of a battery monitor front end: settings decode, alert, balancing, supply
//
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
//
// Overview of operation
// - Gain 4 or 8 by gain bit; zero level 1.0 V or 2.0 V by range.
// - Threshold field selects comparator level between 25 mV and 400 mV.
// - Polarity bit picks discharge or charge current for the comparator.
// - Comparator result drives the open-drain alert pin.
// - Alert pin level readable as a status bit.
// - Bias-enable bit switches the thermistor bias output.
// - Output select 01 with cell select 110 routes internal temperature.
// - Six balance bits each command one balancing FET; no two adjacent FETs on together.
// - Two adjacent requested bits keep both FETs off.
// - Turn on above power-on level; shut down below shutdown level.
// - Leaving shutdown needs power-on level and acts as full reset.
// - Without a deep supply dip, higher power-on level applies.
// - Every power-on reset returns all registers to defaults.
module afe_monitor_control_logic
  import afe_ctrl_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic                  MCLK,
  input  wire logic                  RST,
  // APB slave
  input  wire logic                  PSEL,
  input  wire logic                  PENABLE,
  input  wire logic                  PWRITE,
  input  wire logic [ADDR_W-1:0]     PADDR,
  input  wire logic [31:0]           PWDATA,
  output logic                       PREADY,
  output logic      [31:0]           PRDATA,
  output logic                       PSLVERR,
  // Analog comparator and supply detectors
  input  wire logic                  COMP_TRIP,
  input  wire logic                  SUPPLY_ABOVE_POR,
  input  wire logic                  SUPPLY_ABOVE_POR_HIGH,
  input  wire logic                  SUPPLY_BELOW_SHUT,
  input  wire logic                  SUPPLY_BELOW_DEEP,
  // Open-drain alert pin
  input  wire logic                  ALERT_IN,
  output logic                       ALERT_OUT,
  output logic                       ALERT_OE,
  // Analog controls
  output afe_ctrl_pkg::amp_cfg_t     AMP_CFG,
  output afe_ctrl_pkg::comp_cfg_t    COMP_CFG,
  output logic                       THERM_BIAS_ON,
  output logic                       TEMP_TO_CELL_OUT,
  output logic      [1:0]            CELL_OUT_SEL,
  output logic      [2:0]            CELL_SEL,
  output logic      [BALANCE_FET_BIT-1:0]      BAL_FET_ON,
  // Power state and interrupt
  output logic                       DEVICE_ON,
  output logic                       IRQ
);
  import afe_ctrl_pkg::*;

  initial begin
    if (ADDR_W < 6) $error("afe_monitor_control_logic: ADDR_W too small");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Supply sequencing

  supply_state_t state;
  logic          need_high_por;
  logic          por_pulse;

  // Power-on and shutdown thresholds from the supply detectors
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      state         <= SUP_OFF;
      need_high_por <= 1'b0;
      por_pulse     <= 1'b0;
    end else begin
      por_pulse <= 1'b0;
      case (state)
        SUP_OFF: begin
          if (need_high_por ? SUPPLY_ABOVE_POR_HIGH : SUPPLY_ABOVE_POR) begin
            state     <= SUP_ON;
            por_pulse <= 1'b1;
          end
        end
        SUP_ON: begin
          if (SUPPLY_BELOW_SHUT) begin
            state         <= SUP_SHUT;
            need_high_por <= 1'b1;
          end
        end
        SUP_SHUT: begin
          if (SUPPLY_BELOW_DEEP) begin
            need_high_por <= 1'b0;
          end
          state <= SUP_OFF;
        end
        default: state <= SUP_OFF;
      endcase
      if (state == SUP_OFF && SUPPLY_BELOW_DEEP) begin
        need_high_por <= 1'b0;
      end
    end
  end

  assign DEVICE_ON = (state == SUP_ON);

  //////////////////////////////////////////////////////////////////////////////
  // APB decode

  localparam int WORDS = 8;
  logic        apb_write;
  logic        apb_read;
  logic [2:0]  word_idx;
  logic        in_store;
  logic        in_irq;
  logic        mapped;
  logic [WORDS*8-1:0] words;
  logic [7:0]  store_rdata;
  logic [7:0]  irq_status;
  logic [7:0]  irq_enable;
  logic [7:0]  other_rdata;
  logic        sel_store_q;

  assign apb_write = PSEL && PENABLE && PWRITE;
  assign apb_read  = PSEL && !PENABLE && !PWRITE;
  assign word_idx  = PADDR[4:2];
  assign in_store  = (PADDR <= ADDR_POWER) && (PADDR[1:0] == 2'b00);
  assign in_irq    = (PADDR == ADDR_IRQ_STAT) || (PADDR == ADDR_IRQ_CLR) ||
                     (PADDR == ADDR_IRQ_EN);
  assign mapped    = in_store || in_irq;

  // Zero wait states; unmapped access answers with an error
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !mapped;

  afe_reg_store #(
    .DEPTH (WORDS)
  ) u_store (
    .clk   (MCLK),
    .rst   (RST),
    .clear (por_pulse),
    .we    (apb_write && in_store && PADDR != ADDR_STATUS),
    .waddr (word_idx),
    .wdata (PWDATA[7:0]),
    .raddr (word_idx),
    .rdata (store_rdata),
    .words (words)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Settings decode, live from stored words

  logic [7:0] cell_mux_reg;
  logic [7:0] balance_control_register;
  logic [7:0] config1_reg;
  logic [7:0] config2_reg;
  logic [7:0] power_control_register;
  logic [THR_W-1:0] overcurrent_threshold_field;
  logic       overcurrent_polarity_bit;
  logic       thermistor_bias_enable;
  logic [1:0] cell_output_select;

  assign cell_mux_reg             = words[1*8 +: 8];
  assign balance_control_register = words[2*8 +: 8];
  assign config1_reg              = words[3*8 +: 8];
  assign config2_reg              = words[4*8 +: 8];
  assign power_control_register   = words[5*8 +: 8];
  assign overcurrent_threshold_field = config1_reg[CFG1_THR_LSB +: THR_W];
  assign overcurrent_polarity_bit    = config1_reg[CFG1_POL_BIT];
  assign thermistor_bias_enable      = power_control_register[PWR_BIAS_BIT];
  assign cell_output_select          = cell_mux_reg[OUT_SEL_LSB +: 2];

  assign AMP_CFG.gain    = config1_reg[CFG1_GAIN_BIT] ? GAIN_HIGH : GAIN_LOW;
  assign AMP_CFG.zero_mv = config2_reg[CFG2_RANGE_BIT] ? ZERO_HI_MV : ZERO_LO_MV;

  // threshold level, linear across the span
  assign COMP_CFG.code      = overcurrent_threshold_field;
  assign COMP_CFG.thresh_mv = 9'(THR_MIN_MV + THR_STEP_MV * overcurrent_threshold_field);
  assign COMP_CFG.negative  = overcurrent_polarity_bit;

  assign THERM_BIAS_ON = DEVICE_ON && thermistor_bias_enable;

  assign CELL_OUT_SEL     = cell_output_select;
  assign CELL_SEL         = cell_mux_reg[CELL_SEL_LSB +: 3];
  assign TEMP_TO_CELL_OUT = (cell_output_select == OUT_SEL_TEMP) &&
                            (CELL_SEL == CELL_SEL_TEMP);

  //////////////////////////////////////////////////////////////////////////////
  // Balancing interlock

  logic [BALANCE_FET_BIT-1:0] bal_req;
  logic [BALANCE_FET_BIT-1:0] bal_block;
  assign bal_req = balance_control_register[BALANCE_FET_BIT-1:0];

  genvar b;
  for (b = 0; b < BALANCE_FET_BIT; b++) begin : g_bal
    logic below;
    logic above;
    // Edge cells have one neighbour only
    if (b == 0) begin : g_lo
      assign below = 1'b0;
    end else begin : g_lo
      assign below = bal_req[b-1];
    end
    if (b == BALANCE_FET_BIT-1) begin : g_hi
      assign above = 1'b0;
    end else begin : g_hi
      assign above = bal_req[b+1];
    end
    assign bal_block[b] = bal_req[b] && (below || above);
  end

  // one FET per bit, registered output
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      BAL_FET_ON <= '0;
    end else begin
      BAL_FET_ON <= DEVICE_ON ? (bal_req & ~bal_block) : '0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Alert pin

  logic alert_level;
  logic alert_prev;

  // comparator drives open-drain alert; drive low only
  assign ALERT_OUT = 1'b0;
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      ALERT_OE <= 1'b0;
    end else begin
      ALERT_OE <= DEVICE_ON && COMP_TRIP;
    end
  end

  // Pin level, low while tripped, pulled up when released
  // Reset to the pull-up level so no false edge follows reset
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      alert_level <= 1'b1;
      alert_prev  <= 1'b1;
    end else begin
      alert_level <= ALERT_IN;
      alert_prev  <= alert_level;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interrupts

  logic [IRQ_W-1:0] irq_event;
  logic [IRQ_W-1:0] irq_clr;
  logic             por_flag;

  assign irq_event[IRQ_ALERT_RISE] = alert_level && !alert_prev;
  assign irq_event[IRQ_ALERT_FALL] = !alert_level && alert_prev;
  assign irq_event[IRQ_INTERLOCK]  = |bal_block;
  assign irq_clr = (apb_write && PADDR == ADDR_IRQ_CLR) ? PWDATA[IRQ_W-1:0] : '0;

  // Sticky status; a new event beats a clear in the same cycle
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      irq_status <= 8'h00;
    end else if (por_pulse) begin
      irq_status <= 8'h00;
    end else begin
      irq_status[IRQ_W-1:0] <= (irq_status[IRQ_W-1:0] & ~irq_clr) | irq_event;
    end
  end

  // Enable mask
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      irq_enable <= 8'h00;
    end else if (por_pulse) begin
      irq_enable <= 8'h00;
    end else if (apb_write && PADDR == ADDR_IRQ_EN) begin
      irq_enable <= {5'h00, PWDATA[IRQ_W-1:0]};
    end
  end

  assign IRQ = |(irq_status & irq_enable);

  // Power-on flag, set by each power-on event, cleared by writing 1
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      por_flag <= 1'b1;
    end else if (por_pulse) begin
      por_flag <= 1'b1;
    end else if (apb_write && PADDR == ADDR_STATUS && PWDATA[STAT_POR_BIT]) begin
      por_flag <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read data

  // Status and interrupt words assembled at setup, store data registered on the same edge
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      other_rdata <= 8'h00;
      sel_store_q <= 1'b0;
    end else if (apb_read) begin
      sel_store_q <= in_store && PADDR != ADDR_STATUS;
      if (PADDR == ADDR_STATUS) begin
        other_rdata <= 8'h00;
        other_rdata[STAT_ALERT_BIT] <= alert_level;
        other_rdata[STAT_POR_BIT]   <= por_flag;
      end else if (PADDR == ADDR_IRQ_STAT) begin
        other_rdata <= irq_status;
      end else if (PADDR == ADDR_IRQ_EN) begin
        other_rdata <= irq_enable;
      end else begin
        other_rdata <= 8'h00;
      end
    end
  end

  // Data output selected combinationally in access phase from either source
  always_comb begin
    PRDATA = {24'h000000, sel_store_q ? store_rdata : other_rdata};
  end

  // host open-wire test uses any single FET freely
  // alternative test relies on same individual control
  // host judges increase; no device logic needed

endmodule // afe_monitor_control_logic

// [logic/afe_ctrl_pkg.sv]
// Package: register map, field layout, reset values and types of the monitor control logic
package afe_ctrl_pkg;

  // APB byte addresses (printed offsets are byte addresses)
  localparam logic [7:0] ADDR_STATUS    = 8'h00;
  localparam logic [7:0] ADDR_CELL_MUX  = 8'h04;
  localparam logic [7:0] ADDR_BALANCE   = 8'h08;
  localparam logic [7:0] ADDR_CONFIG1   = 8'h0c;
  localparam logic [7:0] ADDR_CONFIG2   = 8'h10;
  localparam logic [7:0] ADDR_POWER     = 8'h14;
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'h18;
  localparam logic [7:0] ADDR_IRQ_CLR   = 8'h1c;
  localparam logic [7:0] ADDR_IRQ_EN    = 8'h20;

  // Field positions
  localparam int STAT_POR_BIT   = 0;
  localparam int STAT_ALERT_BIT = 2;
  localparam int CFG1_GAIN_BIT  = 0;
  localparam int CFG1_POL_BIT   = 3;
  localparam int CFG1_THR_LSB   = 4;
  localparam int CFG2_RANGE_BIT = 0;
  localparam int PWR_BIAS_BIT   = 1;
  localparam int CELL_SEL_LSB   = 0;
  localparam int OUT_SEL_LSB    = 4;

  // Widths
  localparam int THR_W   = 4;
  localparam int BALANCE_FET_BIT   = 6;
  localparam int IRQ_W   = 3;

  // Internal temperature selection codes
  localparam logic [1:0] OUT_SEL_TEMP  = 2'b01;
  localparam logic [2:0] CELL_SEL_TEMP = 3'b110;

  // Threshold span in mV
  localparam int THR_MIN_MV  = 25;
  localparam int THR_MAX_MV  = 400;
  localparam int THR_STEP_MV = (THR_MAX_MV - THR_MIN_MV) / ((1 << THR_W) - 1);

  // Gain values and zero-current level in mV
  localparam logic [3:0] GAIN_LOW  = 4'h4;
  localparam logic [3:0] GAIN_HIGH = 4'h8;
  localparam logic [11:0] ZERO_LO_MV = 12'h3e8;
  localparam logic [11:0] ZERO_HI_MV = 12'h7d0;

  // Reset values
  localparam logic [7:0] RST_REG = 8'h00;

  // Interrupt bit positions
  localparam int IRQ_ALERT_RISE = 0;
  localparam int IRQ_ALERT_FALL = 1;
  localparam int IRQ_INTERLOCK  = 2;

  // Supply state machine
  typedef enum logic [1:0] {SUP_OFF, SUP_ON, SUP_SHUT} supply_state_t;

  // Decoded amplifier settings
  typedef struct packed {
    logic [3:0]  gain;
    logic [11:0] zero_mv;
  } amp_cfg_t;

  // Decoded comparator settings
  typedef struct packed {
    logic [THR_W-1:0] code;
    logic [8:0]       thresh_mv;
    logic             negative;
  } comp_cfg_t;

endpackage

// [logic/afe_reg_store.sv]
// Small register store: one byte per word address, registered read data
`timescale 1ns/1ps
module afe_reg_store #(
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     clear,
  // Write port
  input  wire logic                     we,
  input  wire logic [$clog2(DEPTH)-1:0] waddr,
  input  wire logic [7:0]               wdata,
  // Read port
  input  wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic      [7:0]               rdata,
  // All words, flat
  output logic      [DEPTH*8-1:0]       words
);
  import afe_ctrl_pkg::*;

  logic [7:0] mem [DEPTH];

  initial begin
    if (DEPTH < 6) $error("afe_reg_store: DEPTH too small");
  end

  // Storage; clear models a full power-on reset
  genvar g;
  for (g = 0; g < DEPTH; g++) begin : g_word
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        mem[g] <= RST_REG;
      end else if (clear) begin
        mem[g] <= RST_REG;
      end else if (we && waddr == g) begin
        mem[g] <= wdata;
      end
    end
    assign words[g*8 +: 8] = mem[g];
  end

  // Registered read
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else begin
      rdata <= mem[raddr];
    end
  end

endmodule // afe_reg_store

// [test/afe_analog_model.sv]
// Analog surroundings: comparator, supply detectors and pulled-up alert pin
`timescale 1ns/1ps
module afe_analog_model
  import afe_ctrl_pkg::*;
(
  // Levels in millivolts
  input  wire logic signed [15:0]      vbat_mv,
  input  wire logic signed [15:0]      sense_mv,
  // Device side
  input  wire afe_ctrl_pkg::comp_cfg_t comp_cfg,
  input  wire logic                    alert_out,
  input  wire logic                    alert_oe,
  output logic                         alert_pin,
  output logic                         comp_trip,
  output logic                         above_por,
  output logic                         above_por_high,
  output logic                         below_shut,
  output logic                         below_deep
);
  logic signed [15:0] thr;

  ////////////////////////////////////////////////////////////////////////////
  // threshold and polarity
  assign thr       = 16'(comp_cfg.thresh_mv);
  assign comp_trip = comp_cfg.negative ? (-sense_mv > thr) : (sense_mv > thr);
  assign above_por      = vbat_mv > 16'sd4700;
  assign above_por_high = vbat_mv > 16'sd7500;
  assign below_shut     = vbat_mv < 16'sd3600;
  assign below_deep     = vbat_mv < 16'sd1400;
  // open drain, pull-up wins when released
  assign alert_pin = alert_oe ? alert_out : 1'b1;
endmodule // afe_analog_model

// [test/afe_ctrl_monitor.sv]
// Port checker of the monitor control logic, bound to its top module
`timescale 1ns/1ps
module afe_ctrl_monitor
  import afe_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic                              MCLK,
  input wire logic                              RST,
  // Detectors
  input wire logic                              COMP_TRIP,
  input wire logic                              SUPPLY_ABOVE_POR,
  input wire logic                              SUPPLY_ABOVE_POR_HIGH,
  input wire logic                              SUPPLY_BELOW_SHUT,
  input wire logic                              SUPPLY_BELOW_DEEP,
  // Controls
  input wire logic                              ALERT_OUT,
  input wire logic                              ALERT_OE,
  input wire afe_ctrl_pkg::amp_cfg_t            AMP_CFG,
  input wire afe_ctrl_pkg::comp_cfg_t           COMP_CFG,
  input wire logic                              THERM_BIAS_ON,
  input wire logic                              TEMP_TO_CELL_OUT,
  input wire logic [1:0]                        CELL_OUT_SEL,
  input wire logic [2:0]                        CELL_SEL,
  input wire logic [afe_ctrl_pkg::BALANCE_FET_BIT-1:0]    BAL_FET_ON,
  input wire logic                              DEVICE_ON
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  ////////////////////////////////////////////////////////////////////////////
  // Shutdown step, then a dip that never gets deep nor high
  sequence shut_s;
    DEVICE_ON && SUPPLY_BELOW_SHUT;
  endsequence
  sequence shallow_s;
    (!SUPPLY_BELOW_DEEP && !SUPPLY_ABOVE_POR_HIGH) [*3];
  endsequence

  gain_value_a: assert property (
    (AMP_CFG.gain == 4'h4 || AMP_CFG.gain == 4'h8) &&
    (AMP_CFG.zero_mv == 12'h3e8 || AMP_CFG.zero_mv == 12'h7d0))
    else $error("amplifier setting outside its two values");
  thresh_step_a: assert property (
    COMP_CFG.thresh_mv == 25 + 25 * COMP_CFG.code)
    else $error("threshold not on the 25 mV ladder");
  alert_drive_a: assert property (
    ALERT_OE == $past(DEVICE_ON && COMP_TRIP) && !ALERT_OUT)
    else $error("alert pin does not follow the comparator");
  bias_gate_a: assert property (THERM_BIAS_ON |-> DEVICE_ON)
    else $error("bias on while device off");
  temp_route_a: assert property (
    TEMP_TO_CELL_OUT == (CELL_OUT_SEL == 2'b01 && CELL_SEL == 3'b110))
    else $error("temperature routing wrong");
  pair_block_a: assert property ((BAL_FET_ON & (BAL_FET_ON >> 1)) == '0)
    else $error("neighbouring balance switches on together");
  shut_down_a: assert property (shut_s |=> !DEVICE_ON)
    else $error("no shutdown below the shutdown level");
  stay_off_a: assert property (!DEVICE_ON && !SUPPLY_ABOVE_POR |=> !DEVICE_ON)
    else $error("turned on below the power-on level");
  high_por_a: assert property (shut_s ##1 shallow_s |=> !DEVICE_ON)
    else $error("restart without the higher power-on level");
endmodule // afe_ctrl_monitor

bind afe_monitor_control_logic afe_ctrl_monitor u_monitor (.MCLK(MCLK), .RST(RST),
  .COMP_TRIP(COMP_TRIP), .SUPPLY_ABOVE_POR(SUPPLY_ABOVE_POR),
  .SUPPLY_ABOVE_POR_HIGH(SUPPLY_ABOVE_POR_HIGH), .SUPPLY_BELOW_SHUT(SUPPLY_BELOW_SHUT),
  .SUPPLY_BELOW_DEEP(SUPPLY_BELOW_DEEP), .ALERT_OUT(ALERT_OUT), .ALERT_OE(ALERT_OE),
  .AMP_CFG(AMP_CFG), .COMP_CFG(COMP_CFG), .THERM_BIAS_ON(THERM_BIAS_ON),
  .TEMP_TO_CELL_OUT(TEMP_TO_CELL_OUT), .CELL_OUT_SEL(CELL_OUT_SEL), .CELL_SEL(CELL_SEL),
  .BAL_FET_ON(BAL_FET_ON), .DEVICE_ON(DEVICE_ON));

// [test/afe_monitor_control_logic_bench.sv]
// Self-checking bench of the monitor control logic
`timescale 1ns/1ps
module afe_monitor_control_logic_bench;
  import afe_ctrl_pkg::*;
  // Bus, detectors and controls
  logic               mclk, rst, psel, penable, pwrite, pready, pslverr, rd_err;
  logic [7:0]         paddr;
  logic [31:0]        pwdata, prdata, rd_data;
  logic               alert_in, alert_out, alert_oe, trip, por, por_hi, shut, deep;
  logic               bias_on, temp_on, dev_on, irq;
  logic [1:0]         out_sel;
  logic [2:0]         cell_sel;
  logic [BALANCE_FET_BIT-1:0]   bal_on;
  logic signed [15:0] vbat_mv, sense_mv;
  amp_cfg_t           amp_cfg;
  comp_cfg_t          comp_cfg;
  int                 bad_count, total_checks;

  afe_monitor_control_logic dut (.MCLK(mclk), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata),
    .PSLVERR(pslverr), .COMP_TRIP(trip), .SUPPLY_ABOVE_POR(por),
    .SUPPLY_ABOVE_POR_HIGH(por_hi), .SUPPLY_BELOW_SHUT(shut), .SUPPLY_BELOW_DEEP(deep),
    .ALERT_IN(alert_in), .ALERT_OUT(alert_out), .ALERT_OE(alert_oe), .AMP_CFG(amp_cfg),
    .COMP_CFG(comp_cfg), .THERM_BIAS_ON(bias_on), .TEMP_TO_CELL_OUT(temp_on),
    .CELL_OUT_SEL(out_sel), .CELL_SEL(cell_sel), .BAL_FET_ON(bal_on),
    .DEVICE_ON(dev_on), .IRQ(irq));
  afe_analog_model model (.vbat_mv(vbat_mv), .sense_mv(sense_mv), .comp_cfg(comp_cfg),
    .alert_out(alert_out), .alert_oe(alert_oe), .alert_pin(alert_in), .comp_trip(trip),
    .above_por(por), .above_por_high(por_hi), .below_shut(shut), .below_deep(deep));

  ////////////////////////////////////////////////////////////////////////////
  // Clock, 4 ns period
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // Watchdog, well past the expected run length
  initial begin
    #100000;
    bad_count++;
    test_done;
  end

  task test_done;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; waits for pready, bounded
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) bad_count++;
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task settle;
    repeat (3) @(posedge mclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Power on, defaults, POR flag
  task t_power_on;
    static logic [7:0] regs [6] = '{ADDR_CELL_MUX, ADDR_BALANCE, ADDR_CONFIG1,
                             ADDR_CONFIG2, ADDR_POWER, ADDR_IRQ_EN};
    check(32'(dev_on), 0);
    vbat_mv <= 16'sd5000;
    settle;
    check(32'(dev_on), 1);
    foreach (regs[i]) begin
      apb(1'b0, regs[i], 0);
      check(rd_data, 0);
    end
    apb(1'b0, ADDR_STATUS, 0);
    check(32'(rd_data[STAT_POR_BIT]), 1);
    check(32'(rd_data[STAT_ALERT_BIT]), 1);
    apb(1'b1, ADDR_STATUS, 1);
    apb(1'b0, ADDR_STATUS, 0);
    check(32'(rd_data[STAT_POR_BIT]), 0);
  endtask
  task t_amp;
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, ADDR_CONFIG1, 32'(i[0]));
      apb(1'b1, ADDR_CONFIG2, 32'(i[1]));
      settle;
      check(32'(amp_cfg.gain), i[0] ? 32'h8 : 32'h4);
      check(32'(amp_cfg.zero_mv), i[1] ? 32'h7d0 : 32'h3e8);
    end
  endtask
  // Every threshold code and polarity, then trips in both polarities at one threshold
  task t_comp;
    for (int i = 0; i < 32; i++) begin
      apb(1'b1, ADDR_CONFIG1, 32'(i << 3));
      settle;
      check(32'(comp_cfg.thresh_mv), 25 + 25 * (i >> 1));
      check(32'(comp_cfg.negative), i & 1);
    end
    sense_mv <= 16'sd300;
    apb(1'b1, ADDR_CONFIG1, 32'ha0);
    settle;
    check(32'(alert_oe), 1);
    check(32'(alert_in), 0);
    apb(1'b0, ADDR_STATUS, 0);
    check(32'(rd_data[STAT_ALERT_BIT]), 0);
    sense_mv <= -16'sd300;
    settle;
    check(32'(alert_oe), 0);
    apb(1'b1, ADDR_CONFIG1, 32'ha8);
    settle;
    check(32'(alert_oe), 1);
    sense_mv <= -16'sd250;
    settle;
    check(32'(alert_oe), 0);
  endtask
  // Sticky events, mask, clear, refused writes, unmapped address
  task t_irq;
    apb(1'b1, ADDR_IRQ_CLR, 7);
    sense_mv <= -16'sd300;
    settle;
    sense_mv <= 16'sd0;
    settle;
    check(32'(irq), 0);
    apb(1'b0, ADDR_IRQ_STAT, 0);
    check(rd_data, 3);
    apb(1'b1, ADDR_IRQ_EN, 2);
    settle;
    check(32'(irq), 1);
    apb(1'b1, ADDR_IRQ_CLR, 2);
    apb(1'b1, ADDR_IRQ_STAT, 32'hff);
    settle;
    check(32'(irq), 0);
    apb(1'b0, ADDR_IRQ_STAT, 0);
    check(rd_data, 1);
    apb(1'b0, 8'h40, 0);
    check(32'(rd_err), 1);
    check(rd_data, 0);
  endtask
  task t_bal;
    static logic [5:0] req [6] = '{6'h15, 6'h2a, 6'h03, 6'h0b, 6'h3f, 6'h21};
    foreach (req[i]) begin
      apb(1'b1, ADDR_BALANCE, 32'(req[i]));
      settle;
      check(32'(bal_on), 32'(req[i] & ~(req[i] << 1) & ~(req[i] >> 1)));
    end
    apb(1'b1, ADDR_IRQ_EN, 4);
    settle;
    check(32'(irq), 1);
    apb(1'b1, ADDR_BALANCE, 32'h01);
    apb(1'b1, ADDR_IRQ_CLR, 4);
    settle;
    check(32'(irq), 0);
    // lone FET below the cell under test
    check(32'(bal_on), 32'h01);
    // lone FET at the input under test
    apb(1'b1, ADDR_BALANCE, 32'h02);
    settle;
    check(32'(bal_on), 32'h02);
  endtask
  task t_bias_temp;
    static logic [7:0] mux [4] = '{8'h16, 8'h26, 8'h15, 8'h17};
    apb(1'b1, ADDR_POWER, 2);
    settle;
    check(32'(bias_on), 1);
    apb(1'b1, ADDR_POWER, 0);
    settle;
    check(32'(bias_on), 0);
    foreach (mux[i]) begin
      apb(1'b1, ADDR_CELL_MUX, 32'(mux[i]));
      settle;
      check(32'(temp_on), 32'(mux[i] == 8'h16));
      check(32'({out_sel, cell_sel}), 32'({mux[i][5:4], mux[i][2:0]}));
    end
  endtask
  // Shutdown, shallow dip, high restart, deep dip
  task t_supply;
    vbat_mv <= 16'sd3000;
    settle;
    check(32'(dev_on), 0);
    vbat_mv <= 16'sd5000;
    settle;
    check(32'(dev_on), 0);
    vbat_mv <= 16'sd8000;
    settle;
    check(32'(dev_on), 1);
    apb(1'b0, ADDR_BALANCE, 0);
    check(rd_data, 0);
    apb(1'b0, ADDR_STATUS, 0);
    check(32'(rd_data[STAT_POR_BIT]), 1);
    vbat_mv <= 16'sd1000;
    settle;
    vbat_mv <= 16'sd5000;
    settle;
    check(32'(dev_on), 1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    vbat_mv = 16'sd0;
    sense_mv = 16'sd0;
    bad_count = 0;
    total_checks = 0;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    t_power_on;
    t_amp;
    t_comp;
    t_irq;
    t_bal;
    t_bias_temp;
    t_supply;
    test_done;
  end
endmodule // afe_monitor_control_logic_bench
